// File: rtl/qdp_pkg.sv
// package for the quad data pointer unit: register addresses, field
// positions, reset values and the pointer instruction codes.
// assumes an 8-bit special register space driven by the processor core.
package qdp_pkg;

   // pointer geometry
   localparam int unsigned QDP_PTR_W   = 24;
   localparam int unsigned QDP_NUM_PTR = 4;

   // pointer byte addresses in the special register space
   localparam logic [7:0] QDP_ADDR_P0_LOW  = 8'h82;
   localparam logic [7:0] QDP_ADDR_P0_HIGH = 8'h83;
   localparam logic [7:0] QDP_ADDR_P0_EXT  = 8'h93;
   localparam logic [7:0] QDP_ADDR_P1_LOW  = 8'h84;
   localparam logic [7:0] QDP_ADDR_P1_HIGH = 8'h85;
   localparam logic [7:0] QDP_ADDR_P1_EXT  = 8'h95;
   localparam logic [7:0] QDP_ADDR_P2_LOW  = 8'hf2;
   localparam logic [7:0] QDP_ADDR_P2_HIGH = 8'hf3;
   localparam logic [7:0] QDP_ADDR_P2_EXT  = 8'heb;
   localparam logic [7:0] QDP_ADDR_P3_LOW  = 8'hf4;
   localparam logic [7:0] QDP_ADDR_P3_HIGH = 8'hf5;
   localparam logic [7:0] QDP_ADDR_P3_EXT  = 8'hed;

   // select and control register addresses
   localparam logic [7:0] QDP_ADDR_SEL_CTL  = 8'h86;
   localparam logic [7:0] QDP_ADDR_SEL_CTL2 = 8'he3;

   // byte lane codes inside one pointer
   localparam logic [1:0] QDP_LANE_LOW  = 2'h0;
   localparam logic [1:0] QDP_LANE_HIGH = 2'h1;
   localparam logic [1:0] QDP_LANE_EXT  = 2'h2;

   // field positions in pointer_select_control
   localparam int unsigned QDP_SEL_LO_BIT  = 0;
   localparam int unsigned QDP_SEL_HI_BIT  = 3;
   localparam int unsigned QDP_ADV_EN_BIT  = 4;
   localparam int unsigned QDP_TOG_EN_BIT  = 5;
   localparam int unsigned QDP_DIR_LO_BIT  = 6;
   localparam int unsigned QDP_DIR_HI_BIT  = 7;

   // reset values
   localparam logic [23:0] QDP_PTR_RST = 24'h000000;
   localparam logic [7:0]  QDP_CTL_RST = 8'h00;

   // pointer-related instruction completing this cycle
   typedef enum logic [2:0] {
      QDP_OP_NONE,
      QDP_OP_INC,
      QDP_OP_LOAD16,
      QDP_OP_LOAD24,
      QDP_OP_MOVC,
      QDP_OP_MOVX_RD,
      QDP_OP_MOVX_WR
   } qdp_op_t;

endpackage

// File: rtl/qdp_step.sv
// one-step 24-bit pointer adjuster, increment or decrement.
// assumes the caller selects the pointer and decides whether to use it.
`timescale 1ns/1ps
module qdp_step
   import qdp_pkg::*;
(
   input  wire logic [23:0] i_value,
   input  wire logic        i_down,
   output logic      [23:0] o_value
);

   // full-width carry or borrow, wrapping at both ends of the range
   always_comb begin
      if (i_down) begin
         o_value = i_value - 24'h000001;
      end else begin
         o_value = i_value + 24'h000001;
      end
   end

endmodule

// File: rtl/qdp_unit.sv
// quad data pointer unit: four 24-bit pointers with select, direction,
// auto-toggle and auto-advance, reached through the special register space.
// assumes the core gives one instruction event per cycle on the same clock
// and drives single-cycle register read and write strobes.
`timescale 1ns/1ps

module qdp_unit
   import qdp_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_arst_n,
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic [7:0]  i_sfr_wdata,
   input  wire logic        i_sfr_rd,
   input  wire qdp_op_t     i_op,
   input  wire logic [23:0] i_load_value,
   output logic      [7:0]  o_sfr_rdata,
   output logic             o_sfr_hit,
   output logic      [23:0] o_active_ptr,
   output logic      [1:0]  o_active_sel
);

   // decoded address: {hit, pointer index, byte lane}
   function automatic logic [4:0] map_addr(input logic [7:0] addr);
      logic [4:0] res;
      res = 5'h00;
      case (addr)
         QDP_ADDR_P0_LOW:  res = {1'b1, 2'h0, QDP_LANE_LOW};
         QDP_ADDR_P0_HIGH: res = {1'b1, 2'h0, QDP_LANE_HIGH};
         QDP_ADDR_P0_EXT:  res = {1'b1, 2'h0, QDP_LANE_EXT};
         QDP_ADDR_P1_LOW:  res = {1'b1, 2'h1, QDP_LANE_LOW};
         QDP_ADDR_P1_HIGH: res = {1'b1, 2'h1, QDP_LANE_HIGH};
         QDP_ADDR_P1_EXT:  res = {1'b1, 2'h1, QDP_LANE_EXT};
         QDP_ADDR_P2_LOW:  res = {1'b1, 2'h2, QDP_LANE_LOW};
         QDP_ADDR_P2_HIGH: res = {1'b1, 2'h2, QDP_LANE_HIGH};
         QDP_ADDR_P2_EXT:  res = {1'b1, 2'h2, QDP_LANE_EXT};
         QDP_ADDR_P3_LOW:  res = {1'b1, 2'h3, QDP_LANE_LOW};
         QDP_ADDR_P3_HIGH: res = {1'b1, 2'h3, QDP_LANE_HIGH};
         QDP_ADDR_P3_EXT:  res = {1'b1, 2'h3, QDP_LANE_EXT};
         default:          res = 5'h00;
      endcase
      return res;
   endfunction

   // pointer and control state
   logic [23:0] ptr_reg      [QDP_NUM_PTR];
   logic [23:0] ptr_next     [QDP_NUM_PTR];
   logic [3:0]  dir_reg;
   logic [3:0]  dir_next;
   logic        sel_hi_reg;
   logic        sel_hi_next;
   logic        sel_lo_reg;
   logic        sel_lo_next;
   logic        tog_en_reg;
   logic        tog_en_next;
   logic        adv_en_reg;
   logic        adv_en_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        hit_reg;
   logic        hit_next;
   logic [23:0] act_reg;
   logic [23:0] act_next;

   logic [1:0]  act_idx;
   logic [23:0] act_ptr;
   logic        act_dir;
   logic [23:0] step_ptr;
   logic [4:0]  wr_map;
   logic [4:0]  rd_map;
   logic [7:0]  ctl_rd;
   logic [7:0]  ctl2_rd;
   logic        does_tog;
   logic        does_adv;

   // active pointer from the select pair
   assign act_idx = {sel_hi_reg, sel_lo_reg};
   assign act_ptr = ptr_reg[act_idx];
   assign act_dir = dir_reg[act_idx];
   assign wr_map  = map_addr(i_sfr_addr);
   assign rd_map  = map_addr(i_sfr_addr);

   // control images; bits 2 and 1 are absent and read as zero so that an
   // increment of the whole register carries out into nothing
   assign ctl_rd  = {dir_reg[1], dir_reg[0], tog_en_reg, adv_en_reg,
                     sel_hi_reg, 2'b00, sel_lo_reg};
   assign ctl2_rd = {dir_reg[3], dir_reg[2], 6'h00};

   // which instructions toggle and which advance
   assign does_tog = tog_en_reg && (i_op != QDP_OP_NONE);
   assign does_adv = adv_en_reg && (i_op == QDP_OP_MOVC ||
                                    i_op == QDP_OP_MOVX_RD ||
                                    i_op == QDP_OP_MOVX_WR);

   // single stepper serves the active pointer only
   qdp_step u_step (
      .i_value (act_ptr),
      .i_down  (act_dir),
      .o_value (step_ptr)
   );

   // next state: instruction effect first, then a register write on top,
   // so software writes win over a same-cycle instruction on that byte
   always_comb begin
      ptr_next    = ptr_reg;
      dir_next    = dir_reg;
      sel_hi_next = sel_hi_reg;
      sel_lo_next = sel_lo_reg;
      tog_en_next = tog_en_reg;
      adv_en_next = adv_en_reg;
      case (i_op)
         QDP_OP_INC: begin
            ptr_next[act_idx] = step_ptr;
         end
         QDP_OP_LOAD16: begin
            ptr_next[act_idx][15:0] = i_load_value[15:0];
         end
         QDP_OP_LOAD24: begin
            ptr_next[act_idx] = i_load_value;
         end
         QDP_OP_MOVC, QDP_OP_MOVX_RD, QDP_OP_MOVX_WR: begin
            if (does_adv) begin
               ptr_next[act_idx] = step_ptr;
            end
         end
         default: begin
         end
      endcase
      // flip only the low select, after the pointer was used
      if (does_tog) begin
         sel_lo_next = ~sel_lo_reg;
      end
      if (i_sfr_wr) begin
         if (wr_map[4]) begin
            case (wr_map[1:0])
               QDP_LANE_LOW:  ptr_next[wr_map[3:2]][7:0]   = i_sfr_wdata;
               QDP_LANE_HIGH: ptr_next[wr_map[3:2]][15:8]  = i_sfr_wdata;
               QDP_LANE_EXT:  ptr_next[wr_map[3:2]][23:16] = i_sfr_wdata;
               default: begin
               end
            endcase
         end else if (i_sfr_addr == QDP_ADDR_SEL_CTL) begin
            sel_lo_next = i_sfr_wdata[QDP_SEL_LO_BIT];
            sel_hi_next = i_sfr_wdata[QDP_SEL_HI_BIT];
            adv_en_next = i_sfr_wdata[QDP_ADV_EN_BIT];
            tog_en_next = i_sfr_wdata[QDP_TOG_EN_BIT];
            dir_next[0] = i_sfr_wdata[QDP_DIR_LO_BIT];
            dir_next[1] = i_sfr_wdata[QDP_DIR_HI_BIT];
         end else if (i_sfr_addr == QDP_ADDR_SEL_CTL2) begin
            dir_next[2] = i_sfr_wdata[QDP_DIR_LO_BIT];
            dir_next[3] = i_sfr_wdata[QDP_DIR_HI_BIT];
         end
      end
   end

   // read path and registered active pointer
   always_comb begin
      rdata_next = 8'h00;
      hit_next   = 1'b0;
      if (i_sfr_rd) begin
         if (rd_map[4]) begin
            hit_next = 1'b1;
            case (rd_map[1:0])
               QDP_LANE_LOW:  rdata_next = ptr_reg[rd_map[3:2]][7:0];
               QDP_LANE_HIGH: rdata_next = ptr_reg[rd_map[3:2]][15:8];
               QDP_LANE_EXT:  rdata_next = ptr_reg[rd_map[3:2]][23:16];
               default:       rdata_next = 8'h00;
            endcase
         end else if (i_sfr_addr == QDP_ADDR_SEL_CTL) begin
            hit_next   = 1'b1;
            rdata_next = ctl_rd;
         end else if (i_sfr_addr == QDP_ADDR_SEL_CTL2) begin
            hit_next   = 1'b1;
            rdata_next = ctl2_rd;
         end
      end
      act_next = ptr_next[{sel_hi_next, sel_lo_next}];
   end

   // state registers
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = 0; k < QDP_NUM_PTR; k++) begin
            ptr_reg[k] <= QDP_PTR_RST;
         end
         dir_reg    <= QDP_CTL_RST[3:0];
         sel_hi_reg <= 1'b0;
         sel_lo_reg <= 1'b0;
         tog_en_reg <= 1'b0;
         adv_en_reg <= 1'b0;
         rdata_reg  <= QDP_CTL_RST;
         hit_reg    <= 1'b0;
         act_reg    <= QDP_PTR_RST;
      end else begin
         ptr_reg    <= ptr_next;
         dir_reg    <= dir_next;
         sel_hi_reg <= sel_hi_next;
         sel_lo_reg <= sel_lo_next;
         tog_en_reg <= tog_en_next;
         adv_en_reg <= adv_en_next;
         rdata_reg  <= rdata_next;
         hit_reg    <= hit_next;
         act_reg    <= act_next;
      end
   end

   assign o_sfr_rdata  = rdata_reg;
   assign o_sfr_hit    = hit_reg;
   assign o_active_ptr = act_reg;
   assign o_active_sel = {sel_hi_reg, sel_lo_reg};

   // helper state read only by the checks below
   logic [1:0]  last_idx_reg;
   logic [23:0] far_ptr;
   logic [7:0]  p0_low;
   logic [7:0]  p2_ext;
   assign far_ptr = ptr_reg[act_idx ^ 2'b10];
   assign p0_low  = ptr_reg[0][7:0];
   assign p2_ext  = ptr_reg[2][23:16];

   // remembers which pointer the previous cycle used
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         last_idx_reg <= 2'b00;
      end else begin
         last_idx_reg <= act_idx;
      end
   end

   inc_up_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_op == QDP_OP_INC && !act_dir && !i_sfr_wr)
      |=> ptr_reg[last_idx_reg] == $past(act_ptr) + 24'h000001)
      else $error("increment did not add one");

   inc_down_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_op == QDP_OP_INC && act_dir && !i_sfr_wr)
      |=> ptr_reg[last_idx_reg] == $past(act_ptr) - 24'h000001)
      else $error("decrement did not subtract one");

   tog_pair_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (tog_en_reg && i_op != QDP_OP_NONE && !i_sfr_wr)
      |=> (sel_lo_reg != $past(sel_lo_reg)) && $stable(sel_hi_reg))
      else $error("toggle did not stay in the pair");

   no_tog_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (!tog_en_reg && !i_sfr_wr) |=> $stable(o_active_sel))
      else $error("select moved with toggle off");

   adv_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (adv_en_reg && tog_en_reg && !act_dir && i_op == QDP_OP_MOVX_RD && !i_sfr_wr)
      |=> ptr_reg[last_idx_reg] == $past(act_ptr) + 24'h000001
          && o_active_sel == {$past(sel_hi_reg), ~$past(sel_lo_reg)})
      else $error("copy step failed");

   no_adv_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (!adv_en_reg && i_op == QDP_OP_MOVC && !i_sfr_wr)
      |=> ptr_reg[last_idx_reg] == $past(act_ptr))
      else $error("pointer moved with advance off");

   first_use_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_op == QDP_OP_LOAD24 && !i_sfr_wr)
      |=> ptr_reg[last_idx_reg] == $past(i_load_value))
      else $error("load went to the wrong pointer");

   other_pair_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_op != QDP_OP_NONE && !i_sfr_wr)
      |=> ptr_reg[last_idx_reg ^ 2'b10] == $past(far_ptr))
      else $error("unselected pointer changed");

   rd_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_sfr_rd && i_sfr_addr == QDP_ADDR_P0_LOW)
      |=> o_sfr_hit && o_sfr_rdata == $past(p0_low))
      else $error("pointer 0 low byte read wrong");

   rd_ext_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_sfr_rd && i_sfr_addr == QDP_ADDR_P2_EXT)
      |=> o_sfr_rdata == $past(p2_ext))
      else $error("pointer 2 ext byte read wrong");

   wr_byte_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_sfr_wr && i_sfr_addr == QDP_ADDR_P3_HIGH)
      |=> ptr_reg[3][15:8] == $past(i_sfr_wdata))
      else $error("pointer 3 high byte write lost");

   ctl_gap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_sfr_rd && i_sfr_addr == QDP_ADDR_SEL_CTL) |=> o_sfr_rdata[2:1] == 2'b00)
      else $error("absent select bits read nonzero");

   dir_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_sfr_wr && i_sfr_addr == QDP_ADDR_SEL_CTL2)
      |=> dir_reg[3:2] == $past(i_sfr_wdata[7:6]) && $stable(dir_reg[1:0]))
      else $error("direction bits misplaced");

   sel_code_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_sfr_wr && i_sfr_addr == QDP_ADDR_SEL_CTL && i_op == QDP_OP_NONE)
      |=> o_active_sel == {$past(i_sfr_wdata[QDP_SEL_HI_BIT]), $past(i_sfr_wdata[QDP_SEL_LO_BIT])}
          && o_active_ptr == ptr_reg[{$past(i_sfr_wdata[QDP_SEL_HI_BIT]),
                                      $past(i_sfr_wdata[QDP_SEL_LO_BIT])}])
      else $error("select code picked wrong pointer");

endmodule

// File: testbench/qdp_core_model.sv
// core model: drives the special register bus and the pointer instruction port.
// assumes one clock shared with the unit; strobes are single-cycle pulses.
`timescale 1ns/1ps
module qdp_core_model
   import qdp_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic [7:0]  i_sfr_rdata,
   input  wire logic        i_sfr_hit,
   output logic      [7:0]  o_sfr_addr,
   output logic             o_sfr_wr,
   output logic      [7:0]  o_sfr_wdata,
   output logic             o_sfr_rd,
   output qdp_op_t          o_op,
   output logic      [23:0] o_load_value
);
   // idle bus at time zero
   initial begin
      o_sfr_addr   = 8'h00;
      o_sfr_wr     = 1'b0;
      o_sfr_wdata  = 8'h00;
      o_sfr_rd     = 1'b0;
      o_op         = QDP_OP_NONE;
      o_load_value = 24'h000000;
   end
   // one write; data is scrambled afterwards so a late sample cannot pass
   task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clk_sys);
      o_sfr_addr  <= addr;
      o_sfr_wdata <= data;
      o_sfr_wr    <= 1'b1;
      @(posedge i_clk_sys);
      o_sfr_wr    <= 1'b0;
      o_sfr_wdata <= ~data;
   endtask
   // read answer stands for one cycle after the taking edge
   task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data, output logic hit);
      @(posedge i_clk_sys);
      o_sfr_addr <= addr;
      o_sfr_rd   <= 1'b1;
      @(posedge i_clk_sys);
      o_sfr_rd   <= 1'b0;
      #1;
      data = i_sfr_rdata;
      hit  = i_sfr_hit;
   endtask
   // one pointer instruction completing in a single cycle
   task automatic issue(input qdp_op_t op, input logic [23:0] value);
      @(posedge i_clk_sys);
      o_op         <= op;
      o_load_value <= value;
      @(posedge i_clk_sys);
      o_op         <= QDP_OP_NONE;
      o_load_value <= ~value;
   endtask
endmodule

// File: testbench/qdp_unit_tb.sv
// self-checking bench for the quad data pointer unit.
// assumes the core model above is the only driver of the unit's bus and instruction inputs.
`timescale 1ns/1ps
module qdp_unit_tb;
   import qdp_pkg::*;
   logic        i_clk_sys;
   logic        i_arst_n;
   logic [7:0]  sfr_addr;
   logic        sfr_wr;
   logic [7:0]  sfr_wdata;
   logic        sfr_rd;
   qdp_op_t     op;
   logic [23:0] load_value;
   logic [7:0]  o_sfr_rdata;
   logic        o_sfr_hit;
   logic [23:0] o_active_ptr;
   logic [1:0]  o_active_sel;
   int          failures;
   int          num_checks;
   int          cycles;
   logic [7:0]  a_ext [4] = '{8'h93, 8'h95, 8'heb, 8'hed};
   logic [7:0]  a_hi  [4] = '{8'h83, 8'h85, 8'hf3, 8'hf5};
   logic [7:0]  a_lo  [4] = '{8'h82, 8'h84, 8'hf2, 8'hf4};

   qdp_unit qdp_unit_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_sfr_addr(sfr_addr),
      .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata), .i_sfr_rd(sfr_rd), .i_op(op),
      .i_load_value(load_value), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
      .o_active_ptr(o_active_ptr), .o_active_sel(o_active_sel));
   qdp_core_model qdp_core_model_i (.i_clk_sys(i_clk_sys), .i_sfr_rdata(o_sfr_rdata),
      .i_sfr_hit(o_sfr_hit), .o_sfr_addr(sfr_addr), .o_sfr_wr(sfr_wr),
      .o_sfr_wdata(sfr_wdata), .o_sfr_rd(sfr_rd), .o_op(op), .o_load_value(load_value));

   // 200 MHz core clock
   initial i_clk_sys = 1'b0;
   always #2.5 i_clk_sys = ~i_clk_sys;

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // distinct bytes per pointer so an address mix-up shows
   function automatic logic [23:0] pat(input int n);
      return {8'ha0 + 8'(n), 8'hb0 + 8'(n), 8'hc0 + 8'(n)};
   endfunction
   task automatic set_ptr(input int n, input logic [23:0] v);
      qdp_core_model_i.sfr_write(a_ext[n], v[23:16]);
      qdp_core_model_i.sfr_write(a_hi[n], v[15:8]);
      qdp_core_model_i.sfr_write(a_lo[n], v[7:0]);
   endtask
   task automatic get_ptr(input int n, output logic [23:0] v);
      logic h;
      qdp_core_model_i.sfr_read(a_ext[n], v[23:16], h);
      qdp_core_model_i.sfr_read(a_hi[n], v[15:8], h);
      qdp_core_model_i.sfr_read(a_lo[n], v[7:0], h);
   endtask
   task automatic wr_ctl(input logic [7:0] c, input logic [7:0] c2);
      qdp_core_model_i.sfr_write(QDP_ADDR_SEL_CTL2, c2);
      qdp_core_model_i.sfr_write(QDP_ADDR_SEL_CTL, c);
   endtask

   task automatic t_regs;
      logic [23:0] v;
      logic [7:0]  d;
      logic        h;
      for (int n = 0; n < 4; n++) begin
         get_ptr(n, v);
         chk("reset ptr", 24'h000000, v);
      end
      for (int n = 0; n < 4; n++) set_ptr(n, pat(n));
      for (int n = 0; n < 4; n++) begin
         get_ptr(n, v);
         chk("ptr bytes", pat(n), v);
      end
      qdp_core_model_i.sfr_read(8'h82, d, h);
      chk("mapped hit", 24'h1, 24'(h));
      @(posedge i_clk_sys);
      #1;
      chk("hit pulse", 24'h0, 24'(o_sfr_hit));
      qdp_core_model_i.sfr_read(8'h00, d, h);
      chk("unmapped hit", 24'h0, 24'(h));
      chk("unmapped data", 24'h0, 24'(d));
      wr_ctl(8'hff, 8'hff);
      qdp_core_model_i.sfr_read(QDP_ADDR_SEL_CTL, d, h);
      chk("ctl gaps", 24'hf9, 24'(d));
      qdp_core_model_i.sfr_read(QDP_ADDR_SEL_CTL2, d, h);
      chk("ctl2 bits", 24'hc0, 24'(d));
      wr_ctl(8'h00, 8'h00);
      $display("done t_regs");
   endtask

   task automatic t_sel;
      logic [7:0] d;
      logic       h;
      for (int s = 0; s < 4; s++) begin
         qdp_core_model_i.sfr_write(QDP_ADDR_SEL_CTL, {4'h0, s[1], 2'b00, s[0]});
         @(posedge i_clk_sys);
         #1;
         chk("active sel", 24'(s), 24'(o_active_sel));
         chk("active ptr", pat(s), o_active_ptr);
      end
      // whole-register increment from select 11 must land on 10
      qdp_core_model_i.sfr_read(QDP_ADDR_SEL_CTL, d, h);
      qdp_core_model_i.sfr_write(QDP_ADDR_SEL_CTL, d + 8'h01);
      #1;
      chk("inc select", 24'h2, 24'(o_active_sel));
      $display("done t_sel");
   endtask

   task automatic t_inc;
      logic [23:0] v;
      wr_ctl(8'h00, 8'h00);
      set_ptr(0, 24'hffffff);
      qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
      get_ptr(0, v);
      chk("inc wrap", 24'h000000, v);
      qdp_core_model_i.sfr_write(QDP_ADDR_SEL_CTL, 8'h40);
      qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
      get_ptr(0, v);
      chk("dec wrap", 24'hffffff, v);
      qdp_core_model_i.sfr_write(QDP_ADDR_SEL_CTL, 8'h81);
      qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
      get_ptr(1, v);
      chk("dec ptr1", pat(1) - 24'h1, v);
      set_ptr(2, 24'h010000);
      wr_ctl(8'h08, 8'h40);
      qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
      get_ptr(2, v);
      chk("dec ptr2", 24'h00ffff, v);
      get_ptr(3, v);
      chk("ptr3 kept", pat(3), v);
      // same-cycle byte write beats the step on that byte only
      fork
         qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
         qdp_core_model_i.sfr_write(a_lo[2], 8'h5a);
      join
      get_ptr(2, v);
      chk("write wins", 24'h00ff5a, v);
      $display("done t_inc");
   endtask

   task automatic t_tog;
      logic [23:0] v;
      qdp_op_t     ops [5] = '{QDP_OP_LOAD16, QDP_OP_LOAD24, QDP_OP_MOVC,
                               QDP_OP_MOVX_RD, QDP_OP_MOVX_WR};
      set_ptr(2, 24'h070100);
      set_ptr(3, 24'h000200);
      wr_ctl(8'h28, 8'h00);
      qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
      qdp_core_model_i.issue(QDP_OP_INC, 24'h0);
      #1;
      chk("sel after 2 inc", 24'h2, 24'(o_active_sel));
      get_ptr(2, v);
      chk("ptr2 inc", 24'h070101, v);
      get_ptr(3, v);
      chk("ptr3 inc", 24'h000201, v);
      for (int i = 0; i < 5; i++) begin
         qdp_core_model_i.issue(ops[i], (i == 0) ? 24'habcdef : 24'h123456);
         #1;
         chk("toggle sel", {22'h0, 1'b1, 1'(i % 2 == 0)}, 24'(o_active_sel));
      end
      get_ptr(2, v);
      chk("load16 ptr2", 24'h07cdef, v);
      get_ptr(3, v);
      chk("load24 ptr3", 24'h123456, v);
      $display("done t_tog");
   endtask

   task automatic t_copy;
      logic [23:0] v;
      set_ptr(2, 24'h00ffff);
      set_ptr(3, 24'h000200);
      wr_ctl(8'h38, 8'h80);
      for (int i = 0; i < 3; i++) begin
         qdp_core_model_i.issue(QDP_OP_MOVX_RD, 24'h0);
         qdp_core_model_i.issue(QDP_OP_MOVX_WR, 24'h0);
      end
      qdp_core_model_i.issue(QDP_OP_MOVC, 24'h0);
      #1;
      chk("copy sel", 24'h3, 24'(o_active_sel));
      get_ptr(2, v);
      chk("copy src", 24'h010003, v);
      get_ptr(3, v);
      chk("copy dst", 24'h0001fd, v);
      $display("done t_copy");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // reset held 16 cycles, then the scenarios in turn
   initial begin
      i_arst_n = 1'b0;
      repeat (16) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      t_regs();
      t_sel();
      t_inc();
      t_tog();
      t_copy();
      end_sim();
   end
endmodule
